// [common/tear_scan_dim_map.vh]
// Command codes, field layout, reset values and timing for the tear, scan-line,
// descriptor, oscillator, power-off and dimmer command decoder.
// Included by the decoder; holds definitions only.
`ifndef TEAR_SCAN_DIM_MAP_VH
`define TEAR_SCAN_DIM_MAP_VH

`define CMD_TEAR_LINE_SET    8'h44
`define CMD_SCAN_LINE_READ   8'h45
`define CMD_DESCRIPTOR_READ  8'ha1
`define CMD_OSC_START        8'hb2
`define CMD_OSC_STOP         8'hb3
`define CMD_POWER_OFF        8'hb4
`define CMD_DIMMER_SET       8'hb5

`define LINE_HI_MSB          1
`define LINE_HI_LSB          0
`define DIM_FIELD_MSB        1
`define DIM_FIELD_LSB        0

`define DESC_OTP_FIRST       4'h8
`define DESC_OTP_LAST        4'hf
`define DESC_EXIT_CODE       8'hff
`define DESC_LEN             4'h8

`define TEAR_LINE_RESET      10'h000
`define DIMMER_RESET         2'h0
`define READ_IDLE_VALUE      8'h00

`define REG_RESET_SETTLE_NS  100
`define CLK_PERIOD_NS        10
`define REG_SETTLE_CYCLES    ((`REG_RESET_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// [rtl/tear_scan_dim_cmds.v]
// Command decoder for tear-line, scan-line readback, descriptor read,
// oscillator start/stop, power-off and dimmer commands.
// Assumes a byte-wide command/parameter stream from the host interface,
// a line counter and frame start strobe from the frame-timing generator,
// and a one-cycle-latency OTP byte port.
`timescale 1ns/1ns
`include "tear_scan_dim_map.vh"

module tear_scan_dim_cmds #(
  parameter LINE_W  = 10,
  parameter PIXEL_W = 8
) (
  input  wire               clk,
  input  wire               rst,
  input  wire               cmd_valid,
  input  wire               cmd_is_command,
  input  wire [7:0]         cmd_byte,
  input  wire               read_req,
  input  wire               sleep_mode,
  input  wire               test_mode,
  input  wire               tear_on_active,
  input  wire               tear_on_mode,
  input  wire               frame_start,
  input  wire               vblank,
  input  wire [LINE_W-1:0]  line_counter,
  input  wire               refresh_transfer,
  input  wire               regulator_good,
  input  wire               otp_programmed,
  input  wire [7:0]         otp_data,
  input  wire [PIXEL_W-1:0] shadow_red,
  input  wire [PIXEL_W-1:0] shadow_green,
  input  wire [PIXEL_W-1:0] shadow_blue,
  output reg  [3:0]         otp_addr,
  output reg  [7:0]         read_data,
  output reg                read_valid,
  output reg                tear_signal,
  output reg                osc_enable,
  output reg                write_clk_enable,
  output reg                power_down,
  output reg                logic_reset,
  output reg  [1:0]         dimmer_level,
  output reg  [PIXEL_W-1:0] pixel_red,
  output reg  [PIXEL_W-1:0] pixel_green,
  output reg  [PIXEL_W-1:0] pixel_blue
);

  localparam [3:0] ST_IDLE  = 4'b0001;
  localparam [3:0] ST_TEAR  = 4'b0010;
  localparam [3:0] ST_DIM   = 4'b0100;
  localparam [3:0] ST_READ  = 4'b1000;

  localparam [2:0] RD_NONE  = 3'b001;
  localparam [2:0] RD_SCAN  = 3'b010;
  localparam [2:0] RD_DESC  = 3'b100;

  reg [3:0]        state;
  reg [2:0]        rd_kind;
  reg              param_idx;
  reg [1:0]        tear_hi;
  reg [LINE_W-1:0] tear_line_pending;
  reg [LINE_W-1:0] tear_line_active;
  reg              tear_line_mode;
  reg              tear_line_mode_active;
  reg              tear_zero_active;
  reg [1:0]        dimmer_pending;
  reg [3:0]        desc_count;
  reg              scan_hi_done;
  reg [LINE_W-1:0] scan_latch;
  reg [7:0]        settle_cnt;
  reg              otp_wait;
  reg [2:0]        reg_good_sync;
  reg              reg_good_q;

  wire cmd_take  = cmd_valid && cmd_is_command;
  wire par_take  = cmd_valid && !cmd_is_command;
  wire tear_hit  = (line_counter == tear_line_active);

  // Command and parameter decode
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state             <= ST_IDLE;
      rd_kind           <= RD_NONE;
      param_idx         <= 1'b0;
      tear_hi           <= 2'h0;
      tear_line_pending <= `TEAR_LINE_RESET;
      tear_line_mode    <= 1'b0;
      dimmer_pending    <= `DIMMER_RESET;
      osc_enable        <= 1'b0;
      write_clk_enable  <= 1'b0;
      power_down        <= 1'b0;
    end else if (cmd_take && !power_down) begin
      param_idx <= 1'b0;
      rd_kind   <= RD_NONE;
      state     <= ST_IDLE;
      case (cmd_byte)
        `CMD_TEAR_LINE_SET: begin
          state <= ST_TEAR;
        end
        `CMD_DIMMER_SET: begin
          state <= ST_DIM;
        end
        `CMD_SCAN_LINE_READ: begin
          state   <= ST_READ;
          rd_kind <= RD_SCAN;
        end
        `CMD_DESCRIPTOR_READ: begin
          state   <= ST_READ;
          rd_kind <= RD_DESC;
        end
        `CMD_OSC_START: begin
          osc_enable       <= 1'b1;
          write_clk_enable <= 1'b1;
        end
        `CMD_OSC_STOP: begin
          // Stopping the clock in normal display would freeze the panel
          if (sleep_mode || test_mode) begin
            osc_enable       <= 1'b0;
            write_clk_enable <= 1'b0;
          end
        end
        `CMD_POWER_OFF: begin
          power_down       <= 1'b1;
          osc_enable       <= 1'b0;
          write_clk_enable <= 1'b0;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end else if (par_take && !power_down) begin
      case (state)
        ST_TEAR: begin
          if (!param_idx) begin
            tear_hi   <= cmd_byte[`LINE_HI_MSB:`LINE_HI_LSB];
            param_idx <= 1'b1;
          end else begin
            tear_line_pending <= {tear_hi, cmd_byte};
            tear_line_mode    <= 1'b1;
            state             <= ST_IDLE;
          end
        end
        ST_DIM: begin
          // Only the level field is kept, so the upper bits can only read as zero
          dimmer_pending <= cmd_byte[`DIM_FIELD_MSB:`DIM_FIELD_LSB];
          state          <= ST_IDLE;
        end
        default: begin
          state <= state;
        end
      endcase
    end
  end

  // Frame-aligned transfer of tear and dimmer settings
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      tear_line_active      <= `TEAR_LINE_RESET;
      tear_line_mode_active <= 1'b0;
      tear_zero_active      <= 1'b0;
      dimmer_level          <= `DIMMER_RESET;
    end else begin
      if (frame_start) begin
        tear_line_active      <= tear_line_pending;
        tear_line_mode_active <= tear_line_mode;
        tear_zero_active      <= (tear_line_pending == `TEAR_LINE_RESET);
      end
      if (refresh_transfer && frame_start) begin
        dimmer_level <= dimmer_pending;
      end
    end
  end

  // Tear output; line compare uses the raw counter, not the access order
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      tear_signal <= 1'b0;
    end else if (sleep_mode || power_down) begin
      tear_signal <= 1'b0;
    end else if (tear_line_mode_active) begin
      if (tear_zero_active) begin
        tear_signal <= vblank;
      end else begin
        tear_signal <= tear_hit;
      end
    end else if (tear_on_active) begin
      tear_signal <= tear_on_mode ? (vblank || tear_hit) : vblank;
    end else begin
      tear_signal <= 1'b0;
    end
  end

  // Read path: scan line and descriptor bytes
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      read_data    <= `READ_IDLE_VALUE;
      read_valid   <= 1'b0;
      otp_addr     <= `DESC_OTP_FIRST;
      desc_count   <= 4'h0;
      scan_hi_done <= 1'b0;
      scan_latch   <= {LINE_W{1'b0}};
      otp_wait     <= 1'b0;
    end else begin
      read_valid <= 1'b0;
      if (cmd_take) begin
        desc_count   <= 4'h0;
        otp_addr     <= `DESC_OTP_FIRST;
        scan_hi_done <= 1'b0;
        // In sleep the counter is not meaningful; it is returned as is
        scan_latch   <= line_counter;
        otp_wait     <= 1'b0;
      end else if (otp_wait) begin
        otp_wait   <= 1'b0;
        read_data  <= otp_data;
        read_valid <= 1'b1;
        desc_count <= desc_count + 4'h1;
        otp_addr   <= otp_addr + 4'h1;
      end else if (read_req && state == ST_READ) begin
        if (rd_kind == RD_SCAN) begin
          read_valid <= 1'b1;
          if (!scan_hi_done) begin
            read_data    <= {6'h00, scan_latch[9:8]};
            scan_hi_done <= 1'b1;
          end else begin
            read_data <= scan_latch[7:0];
          end
        end else if (rd_kind == RD_DESC) begin
          if (otp_programmed && desc_count < `DESC_LEN) begin
            otp_wait <= 1'b1;
          end else begin
            read_data  <= `DESC_EXIT_CODE;
            read_valid <= 1'b1;
          end
        end
      end
    end
  end

  // Regulator flag comes from the analog side; a change counts once two stages agree
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_good_sync <= 3'h0;
      reg_good_q    <= 1'b0;
    end else begin
      reg_good_sync <= {reg_good_sync[1:0], regulator_good};
      if (reg_good_sync[2] == reg_good_sync[1]) begin
        reg_good_q <= reg_good_sync[2];
      end
    end
  end

  // Digital reset held after a power-off exit until the synchronized core-supply flag is good and REG_SETTLE_CYCLES + 1 more cycles have passed
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      logic_reset <= 1'b1;
      settle_cnt  <= 8'h00;
    end else if (!reg_good_q) begin
      logic_reset <= 1'b1;
      settle_cnt  <= 8'h00;
    end else if (settle_cnt < `REG_SETTLE_CYCLES) begin
      settle_cnt <= settle_cnt + 8'h01;
    end else begin
      logic_reset <= 1'b0;
    end
  end

  // Dimmer shift on readout; frame memory itself is never rewritten
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pixel_red   <= {PIXEL_W{1'b0}};
      pixel_green <= {PIXEL_W{1'b0}};
      pixel_blue  <= {PIXEL_W{1'b0}};
    end else begin
      pixel_red   <= shadow_red >> dimmer_level;
      pixel_green <= shadow_green >> dimmer_level;
      pixel_blue  <= shadow_blue >> dimmer_level;
    end
  end

endmodule

// [verification/tear_scan_dim_assertions.sv]
// Checker: cycle relations on the decoder's command, clock, tear and dimmer ports.
// Assumes a bind to the decoder; one clock, asynchronous reset.
`timescale 1ns/1ns
module tear_scan_dim_assertions (
  input wire       clk,
  input wire       rst,
  input wire       cmd_valid,
  input wire       cmd_is_command,
  input wire [7:0] cmd_byte,
  input wire       sleep_mode,
  input wire       test_mode,
  input wire       frame_start,
  input wire       refresh_transfer,
  input wire       osc_enable,
  input wire       power_down,
  input wire       read_valid,
  input wire       tear_signal,
  input wire [1:0] dimmer_level
);
  wire cmd = cmd_valid && cmd_is_command && !power_down;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  chk_osc_start: assert property (cmd && cmd_byte == 8'hb2 |=> osc_enable)
    else $error("osc start lost");
  chk_stop_refused: assert property (cmd && cmd_byte == 8'hb3 && !sleep_mode && !test_mode |=> $stable(osc_enable))
    else $error("osc stop not refused");
  chk_osc_stop: assert property (cmd && cmd_byte == 8'hb3 && (sleep_mode || test_mode) |=> !osc_enable)
    else $error("osc stop lost");
  chk_osc_hold: assert property (!cmd_valid && !power_down |=> $stable(osc_enable))
    else $error("osc moved unasked");
  chk_power_sticky: assert property (power_down |=> power_down)
    else $error("power off left");
  chk_read_pulse: assert property (read_valid |=> !read_valid)
    else $error("read pulse too long");
  chk_tear_sleep: assert property (sleep_mode && $past(sleep_mode) |-> !tear_signal)
    else $error("tear high in sleep");
  chk_dim_hold: assert property (!(frame_start && refresh_transfer) |=> $stable(dimmer_level))
    else $error("dimmer moved mid frame");
endmodule

bind tear_scan_dim_cmds tear_scan_dim_assertions chk (.clk(clk), .rst(rst),
  .cmd_valid(cmd_valid), .cmd_is_command(cmd_is_command), .cmd_byte(cmd_byte),
  .sleep_mode(sleep_mode), .test_mode(test_mode), .frame_start(frame_start),
  .refresh_transfer(refresh_transfer), .osc_enable(osc_enable),
  .power_down(power_down), .read_valid(read_valid), .tear_signal(tear_signal),
  .dimmer_level(dimmer_level));

// [verification/host_model.sv]
// Host model: sends command and parameter bytes, pulls read bytes.
// Assumes the decoder answers a read request within a few cycles.
`timescale 1ns/1ns
module host_model (
  input  wire       clk,
  input  wire       read_valid,
  input  wire [7:0] read_data,
  output reg        cmd_valid,
  output reg        cmd_is_command,
  output reg  [7:0] cmd_byte,
  output reg        read_req
);
  initial {cmd_valid, cmd_is_command, cmd_byte, read_req} = 11'h000;
  task put(input c, input [7:0] b);
    begin
      @(posedge clk) #1;
      {cmd_valid, cmd_is_command, cmd_byte} = {1'b1, c, b};
      @(posedge clk) #1;
      cmd_valid = 1'b0;
      // Released bus shows the inverse so stale bytes never look valid
      cmd_byte = ~b;
    end
  endtask
  task get(output [7:0] d);
    integer n;
    begin
      @(posedge clk) #1;
      read_req = 1'b1;
      @(posedge clk) #1;
      read_req = 1'b0;
      n = 0;
      while (read_valid !== 1'b1 && n < 8) begin
        @(posedge clk) #1;
        n = n + 1;
      end
      d = read_valid === 1'b1 ? read_data : 8'hxx;
      @(posedge clk) #1;
    end
  endtask
endmodule

// [verification/tear_scan_dim_cmds_tb.sv]
// Bench for the tear, scan-line, descriptor, oscillator, power-off and dimmer decoder.
// Assumes host_model as the host and a 20-line frame made here.
`timescale 1ns/1ns
module tear_scan_dim_cmds_tb;
  reg        clk = 0, rst = 1, sleep_mode = 0, test_mode = 0, refresh_transfer = 0;
  reg        regulator_good = 1, otp_programmed = 1, run = 1, frame_start = 0;
  reg        vblank = 1, vb_d = 0, fs_d = 0, e;
  reg  [9:0] line_counter = 10'h000, ln_d = 10'h000;
  reg  [7:0] otp_data = 8'h00, pix = 8'hb7, d;
  reg  [1:0] lv = 2'h0;
  wire       cmd_valid, cmd_is_command, read_req, read_valid, tear_signal;
  wire       osc_enable, power_down, logic_reset;
  wire [7:0] cmd_byte, read_data, pr, pg, pb;
  wire [3:0] otp_addr;
  wire [1:0] dimmer_level;
  integer    fails = 0, cmp_count = 0, i;
  localparam [83:0] OSC = {12'h566, 12'h165, 12'h366, 12'h366, 12'h167, 12'h165, 12'h165};
  host_model host (.clk(clk), .read_valid(read_valid), .read_data(read_data),
    .cmd_valid(cmd_valid), .cmd_is_command(cmd_is_command), .cmd_byte(cmd_byte),
    .read_req(read_req));
  tear_scan_dim_cmds uut (.clk(clk), .rst(rst), .cmd_valid(cmd_valid),
    .cmd_is_command(cmd_is_command), .cmd_byte(cmd_byte), .read_req(read_req),
    .sleep_mode(sleep_mode), .test_mode(test_mode), .tear_on_active(1'b0),
    .tear_on_mode(1'b0), .frame_start(frame_start), .vblank(vblank),
    .line_counter(line_counter), .refresh_transfer(refresh_transfer),
    .regulator_good(regulator_good), .otp_programmed(otp_programmed),
    .otp_data(otp_data), .shadow_red(pix), .shadow_green(pix), .shadow_blue(pix),
    .otp_addr(otp_addr), .read_data(read_data), .read_valid(read_valid),
    .tear_signal(tear_signal), .osc_enable(osc_enable), .write_clk_enable(),
    .power_down(power_down), .logic_reset(logic_reset), .dimmer_level(dimmer_level),
    .pixel_red(pr), .pixel_green(pg), .pixel_blue(pb));
  initial forever #5 clk = ~clk;
  always @(posedge clk) begin
    {vb_d, fs_d, ln_d} <= {vblank, frame_start, line_counter};
    otp_data <= #1 {4'ha, otp_addr};
    #1;
    if (run) line_counter = line_counter == 10'h013 ? 10'h000 : line_counter + 10'h001;
    frame_start = run && line_counter == 10'h000;
    vblank = line_counter < 10'h004;
  end
  task check(input [25:0] got, input [25:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask
  task tally_and_finish;
    begin
      $display("fails %0d compares %0d", fails, cmp_count);
      if (fails == 0 && cmp_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask
  task tick(input integer n);
    repeat (n) @(posedge clk) #1;
  endtask
  task wait_frame;
    begin
      tick(1);
      while (fs_d !== 1'b1) tick(1);
    end
  endtask
  // Old setting is checked up to the frame start, the new one for the rest of a frame
  task tear_run(input on, input [9:0] o, input [9:0] n);
    begin
      tick(1);
      while (fs_d !== 1'b1) begin
        check(tear_signal, !sleep_mode && on && (o == 0 ? vb_d : ln_d == o));
        tick(1);
      end
      repeat (19) begin
        tick(1);
        check(tear_signal, !sleep_mode && (n == 0 ? vb_d : ln_d == n));
      end
    end
  endtask
  initial begin
    tick(16);
    rst = 0;
    tick(20);
    check({tear_signal, osc_enable, power_down, dimmer_level, logic_reset}, 0);
    host.put(1'b1, 8'h44);
    host.put(1'b0, 8'hfc);
    host.put(1'b0, 8'h05);
    tear_run(1'b0, 10'h000, 10'h005);
    host.put(1'b1, 8'h44);
    host.put(1'b0, 8'h00);
    host.put(1'b0, 8'h00);
    tear_run(1'b1, 10'h005, 10'h000);
    sleep_mode = 1;
    tear_run(1'b1, 10'h000, 10'h000);
    for (i = 0; i < 7; i = i + 1) begin
      {sleep_mode, test_mode, d, e} = OSC[i*12 +: 11];
      host.put(1'b1, d);
      tick(1);
      check(osc_enable, e);
    end
    sleep_mode = 0;
    test_mode = 0;
    for (i = 3; i >= 0; i = i - 1) begin
      refresh_transfer = 0;
      host.put(1'b1, 8'hb5);
      host.put(1'b0, {6'h3f, i[1:0]});
      wait_frame;
      check(dimmer_level, lv);
      refresh_transfer = 1;
      wait_frame;
      tick(1);
      check({dimmer_level, pr, pg, pb}, {i[1:0], {3{pix >> i}}});
      lv = i[1:0];
    end
    run = 0;
    line_counter = 10'h2c5;
    host.put(1'b1, 8'h45);
    host.get(d);
    check(d, 8'h02);
    host.get(d);
    check(d, 8'hc5);
    for (i = 0; i < 12; i = i + 1) begin
      if (i == 10) otp_programmed = 0;
      if (i == 0 || i == 10) host.put(1'b1, 8'ha1);
      host.get(d);
      check(d, i < 8 ? {4'ha, 4'h8 + i[3:0]} : 8'hff);
    end
    host.put(1'b1, 8'hb4);
    host.put(1'b1, 8'hb2);
    tick(1);
    check({power_down, osc_enable}, 2'b10);
    regulator_good = 0;
    rst = 1;
    tick(500);
    rst = 0;
    tick(30);
    check(logic_reset, 1);
    regulator_good = 1;
    tick(30);
    check({logic_reset, power_down, osc_enable, tear_signal}, 0);
    tally_and_finish;
  end
  initial begin
    #200000;
    fails = fails + 1;
    tally_and_finish;
  end
endmodule
